// ==== src/stlt_defs.svh ====
// Offsets, field positions, reset values and timing counts of the TLB staging and timer registers
`ifndef STLT_DEFS_SVH
`define STLT_DEFS_SVH

// Register selector values
`define STLT_OFF_EVEN     5'h02
`define STLT_OFF_ODD      5'h03
`define STLT_OFF_MISS     5'h04
`define STLT_OFF_SIZE     5'h05
`define STLT_OFF_FIXED    5'h06
`define STLT_OFF_FAULT    5'h08
`define STLT_OFF_TICK     5'h09
`define STLT_OFF_MATCH    5'h0B

// Page descriptor fields
`define STLT_NC_HI        63
`define STLT_NC_LO        62
`define STLT_FRM_HI       33
`define STLT_FRM_LO       6
`define STLT_SHARED_BIT   0
`define STLT_OK_BIT       1
`define STLT_DESC_MASK    64'hC000_0003_FFFF_FFFF

// Miss pointer fields
`define STLT_BASE_LO      23
`define STLT_PAIR_HI      22
`define STLT_PAIR_LO      4
`define STLT_VA_PAIR_HI   31
`define STLT_VA_PAIR_LO   13

// Page size select fields
`define STLT_SIZE_HI      24
`define STLT_SIZE_LO      13

// Fixed boundary width and reset
`define STLT_FIXED_W      6
`define STLT_FIXED_RST    6'h00

// Timer: one tick per two processor clocks
`define STLT_TICK_DIV     1'h1

`endif

// ==== src/stlt_pkg.sv ====
// Types shared by the TLB staging and timer register files
`default_nettype none
package stlt_pkg;
    typedef logic [4:0]  stlt_sel_t;
    typedef logic [63:0] stlt_word_t;
    typedef logic [11:0] stlt_size_t;
endpackage : stlt_pkg
`default_nettype wire

// ==== src/stlt_desc.sv ====
// One page descriptor register, even or odd
`include "stlt_defs.svh"
`default_nettype none
module stlt_desc
    import stlt_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Software write
    input  wire logic       wr_en,
    input  wire logic       wide,
    input  wire stlt_word_t wdata,
    // TLB read return
    input  wire logic       tlb_rd,
    input  wire stlt_word_t tlb_data,
    // Stored value
    output stlt_word_t      desc_q
);
    stlt_word_t sext;
    stlt_word_t desc_d;

    // Narrow writes sign-extend; the attribute bits cannot be set from them
    always_comb
    begin
        sext = {{32{wdata[31]}}, wdata[31:0]};
        if (!wide)
            desc_d = {desc_q[`STLT_NC_HI:`STLT_NC_LO], sext[61:0]};
        else
            desc_d = wdata;
    end

    // Reserved bits are never stored, so they read back as zero
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            desc_q <= 64'h0000_0000_0000_0000;
        else if (ce && wr_en)
            desc_q <= desc_d & `STLT_DESC_MASK;
        else if (ce && tlb_rd)
            desc_q <= tlb_data & `STLT_DESC_MASK;
    end

    // A narrow write leaves the attribute bits as they were
    property p_narrow_keeps_nc;
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_en && !wide) |=> desc_q[63:62] == $past(desc_q[63:62]);
    endproperty
    a_narrow_keeps_nc: assert property (p_narrow_keeps_nc)
        else $error("narrow write changed attribute bits");

    // Bits 33:31 are uniform after a narrow write
    property p_narrow_sext;
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_en && !wide) |=> (desc_q[33:31] == 3'h0 || desc_q[33:31] == 3'h7);
    endproperty
    a_narrow_sext: assert property (p_narrow_sext)
        else $error("bits 33:31 not uniform after narrow write");
endmodule : stlt_desc
`default_nettype wire

// ==== src/stlt_timer.sv ====
// Tick counter and match register with the pending timer flag
`include "stlt_defs.svh"
`default_nettype none
module stlt_timer
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Software writes
    input  wire logic        wr_tick,
    input  wire logic        wr_match,
    input  wire logic [31:0] wdata,
    // State
    output logic      [31:0] tick_q,
    output logic      [31:0] match_q,
    output logic             pend_q
);
    logic phase_q;

    // Divide by two: the counter moves on every second clock
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            phase_q <= 1'b0;
        else if (ce)
            phase_q <= phase_q ^ `STLT_TICK_DIV;
    end

    // Counter wraps freely; a write lands at once
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tick_q <= 32'h0000_0000;
        else if (ce && wr_tick)
            tick_q <= wdata;
        else if (ce && phase_q)
            tick_q <= tick_q + 32'h0000_0001;
    end

    // Match value
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            match_q <= 32'h0000_0000;
        else if (ce && wr_match)
            match_q <= wdata;
    end

    // Set beats clear so a match coinciding with the write is kept
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pend_q <= 1'b0;
        else if (ce && tick_q == match_q)
            pend_q <= 1'b1;
        else if (ce && wr_match)
            pend_q <= 1'b0;
    end

    // A qualifying clock advances the count by exactly one
    property p_tick_rate;
        @(posedge clk) disable iff (!rst_n)
        (ce && !wr_tick && phase_q) |=> tick_q == $past(tick_q) + 32'h0000_0001;
    endproperty
    a_tick_rate: assert property (p_tick_rate)
        else $error("tick did not advance by one");

    property p_tick_hold;
        @(posedge clk) disable iff (!rst_n)
        (ce && !wr_tick && !phase_q) |=> tick_q == $past(tick_q);
    endproperty
    a_tick_hold: assert property (p_tick_hold)
        else $error("tick advanced on the off phase");

    property p_match_sets;
        @(posedge clk) disable iff (!rst_n)
        (ce && tick_q == match_q) |=> pend_q;
    endproperty
    a_match_sets: assert property (p_match_sets)
        else $error("match did not set pending flag");

    property p_write_clears;
        @(posedge clk) disable iff (!rst_n)
        (ce && wr_match && tick_q != match_q) |=> !pend_q;
    endproperty
    a_write_clears: assert property (p_write_clears)
        else $error("match write did not clear pending flag");
endmodule : stlt_timer
`default_nettype wire

// ==== src/stlt_regs.sv ====
// TLB staging, miss capture, replacement pointer and interval timer registers
//
// Overview of operation
// - Even and odd page descriptors, same format
// - Frame number holds physical bits 33:6
// - Two-bit no-cache attribute at 63:62
// - Drive attribute on bus bits 59:58
// - Narrow mode reaches only low 32 bits
// - Narrow writes sign-extend bits 31:0
// - Frame bits filtered; attribute never masked
// - Shared bit set only if both set
// - Hit on invalid entry raises invalid exception
// - Reserved bits read zero; software writes zero
// - Miss loads page pair from bits 31:13
// - Table base is software-only
// - Size mask moves with TLB read/write
// - Other size patterns give undefined behaviour
// - Entries below boundary never randomly replaced
// - Boundary clears to zero at reset
// - Boundary write reloads replacement pointer top
// - Fault address captures latest faulting address
// - Fault address kept on soft reset, NMI
// - Tick and match are 32-bit read/write
// - Tick advances every second clock
// - Equality sets pending interrupt bit seven
// - Match write clears timer pending bit
// - Timer masked only by mask bit seven
// - Pointer decrements on graduation within bounds
// - Reset loads pointer with entries minus one
// - Access needs kernel mode or usable bit
`include "stlt_defs.svh"
`default_nettype none
module stlt_regs
    import stlt_pkg::*;
#(
    parameter int TLB_ENTRIES = 64
)
(
    // Clock, reset and enable
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Privilege
    input  wire logic       kernel_mode,
    input  wire logic       sysctl_usable_bit,
    input  wire logic       wide_ops,
    // Move-to port
    input  wire logic       mt_valid,
    input  wire stlt_sel_t  mt_sel,
    input  wire stlt_word_t mt_wdata,
    // Move-from port
    input  wire logic       mf_valid,
    input  wire stlt_sel_t  mf_sel,
    output stlt_word_t      mf_rdata_q,
    output logic            mf_done_q,
    output logic            unusable_exc_q,
    // TLB array side
    input  wire logic       tlb_write,
    input  wire logic       tlb_write_random,
    input  wire logic       tlb_read,
    input  wire stlt_word_t tlb_rd_even,
    input  wire stlt_word_t tlb_rd_odd,
    input  wire stlt_size_t tlb_rd_size,
    input  wire logic [27:0] frame_bit_filter,
    output logic            tlb_wr_q,
    output stlt_word_t      tlb_wr_even_q,
    output stlt_word_t      tlb_wr_odd_q,
    output logic            tlb_wr_shared_q,
    output stlt_size_t      tlb_wr_size_q,
    output logic [5:0]      tlb_wr_index_q,
    output logic [5:0]      repl_ptr_q,
    // Translation and faults
    input  wire logic       xlat_hit,
    input  wire logic       xlat_entry_ok,
    input  wire logic       xlat_store,
    input  wire logic       tlb_miss,
    input  wire logic       addr_error,
    input  wire logic       hold_fault,
    input  wire stlt_word_t fault_vaddr,
    output logic            tlb_inv_load_q,
    output logic            tlb_inv_store_q,
    // Pipeline and bus
    input  wire logic       graduate,
    input  wire logic       bus_addr_cycle,
    input  wire logic [1:0] bus_entry_nc,
    output logic [1:0]      system_bus_nc_q,
    // Timer interrupt
    input  wire logic       int_enable_bit7,
    output logic            pending_int_bit7_q,
    output logic            timer_irq_q
);
    localparam logic [5:0] TOP = 6'(TLB_ENTRIES - 1);

    stlt_word_t even_q;
    stlt_word_t odd_q;
    logic [40:0] base_q;
    logic [18:0] pair_q;
    stlt_size_t  size_q;
    logic [`STLT_FIXED_W-1:0] fixed_q;
    stlt_word_t  fault_q;
    logic [31:0] tick_q;
    logic [31:0] match_q;
    logic        pend_q;
    logic        allowed;
    logic        wr_ok;
    logic        rd_ok;
    logic        wr_even;
    logic        wr_odd;
    logic        wr_tick;
    logic        wr_match;
    stlt_word_t  rd_raw;
    stlt_word_t  rd_d;
    stlt_word_t  wr_val;
    logic [63:0] frame_clr;

    // Access is allowed in kernel mode or with the usable bit
    assign allowed = kernel_mode | sysctl_usable_bit;
    assign wr_ok   = ce & mt_valid & allowed;
    assign rd_ok   = ce & mf_valid & allowed;
    assign wr_even  = wr_ok && mt_sel == `STLT_OFF_EVEN;
    assign wr_odd   = wr_ok && mt_sel == `STLT_OFF_ODD;
    assign wr_tick  = wr_ok && mt_sel == `STLT_OFF_TICK;
    assign wr_match = wr_ok && mt_sel == `STLT_OFF_MATCH;

    // Narrow mode only reaches the low word, sign-extended
    assign wr_val = wide_ops ? mt_wdata : {{32{mt_wdata[31]}}, mt_wdata[31:0]};

    // Descriptors: software writes and TLB read returns
    stlt_desc u_even (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .wr_en    (wr_even),
        .wide     (wide_ops),
        .wdata    (mt_wdata),
        .tlb_rd   (tlb_read),
        .tlb_data (tlb_rd_even),
        .desc_q   (even_q)
    );
    stlt_desc u_odd (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .wr_en    (wr_odd),
        .wide     (wide_ops),
        .wdata    (mt_wdata),
        .tlb_rd   (tlb_read),
        .tlb_data (tlb_rd_odd),
        .desc_q   (odd_q)
    );

    // Timer block
    stlt_timer u_timer (
        .clk      (clk),
        .rst_n    (rst_n),
        .ce       (ce),
        .wr_tick  (wr_tick),
        .wr_match (wr_match),
        .wdata    (wr_val[31:0]),
        .tick_q   (tick_q),
        .match_q  (match_q),
        .pend_q   (pend_q)
    );

    // Miss pointer: base is software's, pair field is loaded by a miss or a software write, the miss winning
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            base_q <= 41'h000_0000_0000;
        else if (wr_ok && mt_sel == `STLT_OFF_MISS)
            base_q <= wr_val[63:`STLT_BASE_LO];
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            pair_q <= 19'h0_0000;
        else if (ce && tlb_miss)
            pair_q <= fault_vaddr[`STLT_VA_PAIR_HI:`STLT_VA_PAIR_LO];
        else if (wr_ok && mt_sel == `STLT_OFF_MISS)
            pair_q <= wr_val[`STLT_PAIR_HI:`STLT_PAIR_LO];
    end

    // Size mask is stored as written; illegal patterns are not screened
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            size_q <= 12'h000;
        else if (wr_ok && mt_sel == `STLT_OFF_SIZE)
            size_q <= wr_val[`STLT_SIZE_HI:`STLT_SIZE_LO];
        else if (ce && tlb_read)
            size_q <= tlb_rd_size;
    end

    // Fixed boundary
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fixed_q <= `STLT_FIXED_RST;
        else if (wr_ok && mt_sel == `STLT_OFF_FIXED)
            fixed_q <= wr_val[`STLT_FIXED_W-1:0];
    end

    // Replacement pointer counts down, wrapping from the boundary to the top
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            repl_ptr_q <= TOP;
        else if (wr_ok && mt_sel == `STLT_OFF_FIXED)
            repl_ptr_q <= TOP;
        else if (ce && graduate)
        begin
            if (repl_ptr_q <= fixed_q || repl_ptr_q > TOP)
                repl_ptr_q <= TOP;
            else
                repl_ptr_q <= repl_ptr_q - 6'h01;
        end
    end

    // Fault address; a soft reset, NMI or cache error never disturbs it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            fault_q <= 64'h0000_0000_0000_0000;
        else if (ce && (tlb_miss || addr_error || (xlat_hit && !xlat_entry_ok))
                 && !hold_fault)
            fault_q <= fault_vaddr;
    end

    // Frame filter clears selected frame bits only
    assign frame_clr = {30'h0000_0000, frame_bit_filter, 6'h00};

    // TLB write bundle; random writes use the pointer, which never drops below the boundary
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tlb_wr_q        <= 1'b0;
            tlb_wr_even_q   <= 64'h0000_0000_0000_0000;
            tlb_wr_odd_q    <= 64'h0000_0000_0000_0000;
            tlb_wr_shared_q <= 1'b0;
            tlb_wr_size_q   <= 12'h000;
            tlb_wr_index_q  <= 6'h00;
        end
        else if (ce)
        begin
            tlb_wr_q <= tlb_write;
            if (tlb_write)
            begin
                tlb_wr_even_q   <= even_q & ~frame_clr;
                tlb_wr_odd_q    <= odd_q & ~frame_clr;
                tlb_wr_shared_q <= even_q[`STLT_SHARED_BIT] & odd_q[`STLT_SHARED_BIT];
                tlb_wr_size_q   <= size_q;
                if (tlb_write_random)
                    tlb_wr_index_q <= repl_ptr_q;
            end
        end
    end

    // Invalid-entry exceptions, load or store by access kind
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tlb_inv_load_q  <= 1'b0;
            tlb_inv_store_q <= 1'b0;
        end
        else if (ce)
        begin
            tlb_inv_load_q  <= xlat_hit & ~xlat_entry_ok & ~xlat_store;
            tlb_inv_store_q <= xlat_hit & ~xlat_entry_ok & xlat_store;
        end
    end

    // Attribute on the bus address cycle, held otherwise
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            system_bus_nc_q <= 2'h0;
        else if (ce && bus_addr_cycle)
            system_bus_nc_q <= bus_entry_nc;
    end

    // Timer interrupt: only mask bit 7 gates it
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pending_int_bit7_q <= 1'b0;
            timer_irq_q        <= 1'b0;
        end
        else if (ce)
        begin
            pending_int_bit7_q <= pend_q;
            timer_irq_q        <= pend_q & int_enable_bit7;
        end
    end

    // Read mux; unused and reserved bits are zero, then narrow reads sign-extend bit 31 into bits 63:32
    always_comb
    begin
        case (mf_sel)
            `STLT_OFF_EVEN:  rd_raw = even_q;
            `STLT_OFF_ODD:   rd_raw = odd_q;
            `STLT_OFF_MISS:  rd_raw = {base_q, pair_q, 4'h0};
            `STLT_OFF_SIZE:  rd_raw = {39'h0, size_q, 13'h0000};
            `STLT_OFF_FIXED: rd_raw = {58'h0, fixed_q};
            `STLT_OFF_FAULT: rd_raw = fault_q;
            `STLT_OFF_TICK:  rd_raw = {32'h0000_0000, tick_q};
            `STLT_OFF_MATCH: rd_raw = {32'h0000_0000, match_q};
            default:         rd_raw = 64'h0000_0000_0000_0000;
        endcase
        rd_d = wide_ops ? rd_raw : {{32{rd_raw[31]}}, rd_raw[31:0]};
    end

    // Read return and unusable exception
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mf_rdata_q     <= 64'h0000_0000_0000_0000;
            mf_done_q      <= 1'b0;
            unusable_exc_q <= 1'b0;
        end
        else if (ce)
        begin
            mf_done_q      <= rd_ok;
            unusable_exc_q <= (mt_valid | mf_valid) & ~allowed;
            if (rd_ok)
                mf_rdata_q <= rd_d;
        end
    end

    // Boundary write puts the pointer at the top next cycle
    property p_fixed_reload;
        @(posedge clk) disable iff (!rst_n)
        (wr_ok && mt_sel == `STLT_OFF_FIXED) |=> repl_ptr_q == TOP;
    endproperty
    a_fixed_reload: assert property (p_fixed_reload)
        else $error("pointer not reloaded after boundary write");

    // Random writes never target a fixed entry
    property p_random_above_fixed;
        @(posedge clk) disable iff (!rst_n)
        (ce && tlb_write && tlb_write_random && fixed_q <= TOP) |=>
            tlb_wr_index_q >= $past(fixed_q);
    endproperty
    a_random_above_fixed: assert property (p_random_above_fixed)
        else $error("random write chose a fixed entry");

    // Shared bit needs both descriptor bits
    property p_shared_and;
        @(posedge clk) disable iff (!rst_n)
        (ce && tlb_write) |=> tlb_wr_shared_q == ($past(even_q[0]) & $past(odd_q[0]));
    endproperty
    a_shared_and: assert property (p_shared_and)
        else $error("shared bit not the and of both descriptors");

    // Miss loads the page pair from the faulting address
    property p_miss_pair;
        @(posedge clk) disable iff (!rst_n)
        (ce && tlb_miss) |=> pair_q == $past(fault_vaddr[31:13]);
    endproperty
    a_miss_pair: assert property (p_miss_pair)
        else $error("page pair not captured on miss");

    // A miss leaves the table base alone
    property p_miss_keeps_base;
        @(posedge clk) disable iff (!rst_n)
        (ce && tlb_miss && !(wr_ok && mt_sel == `STLT_OFF_MISS)) |=> $stable(base_q);
    endproperty
    a_miss_keeps_base: assert property (p_miss_keeps_base)
        else $error("table base changed on miss");

    // Held faults leave the captured address unchanged
    property p_fault_hold;
        @(posedge clk) disable iff (!rst_n)
        (ce && hold_fault) |=> $stable(fault_q);
    endproperty
    a_fault_hold: assert property (p_fault_hold)
        else $error("fault address changed while held");

    // Refused access writes nothing and raises the exception
    property p_unusable;
        @(posedge clk) disable iff (!rst_n)
        (ce && mt_valid && !allowed) |=> unusable_exc_q && $stable(fixed_q);
    endproperty
    a_unusable: assert property (p_unusable)
        else $error("refused access not reported");

    // Invalid hit reports the right kind a cycle later
    property p_invalid_kind;
        @(posedge clk) disable iff (!rst_n)
        (ce && xlat_hit && !xlat_entry_ok) |=> (tlb_inv_store_q == $past(xlat_store))
            && (tlb_inv_load_q == !$past(xlat_store));
    endproperty
    a_invalid_kind: assert property (p_invalid_kind)
        else $error("invalid exception kind wrong");

    // Timer request follows the pending flag through mask bit 7 only
    property p_irq_mask;
        @(posedge clk) disable iff (!rst_n)
        ce |=> timer_irq_q == ($past(pend_q) & $past(int_enable_bit7));
    endproperty
    a_irq_mask: assert property (p_irq_mask)
        else $error("timer request not gated by mask bit 7");
endmodule : stlt_regs
`default_nettype wire

// ==== tb/stlt_tlb_model.sv ====
// Single-entry TLB array model: keeps each write bundle and returns it on TLB read
`default_nettype none
module stlt_tlb_model
    import stlt_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Write bundle from the registers
    input  wire logic       wr,
    input  wire stlt_word_t wr_even,
    input  wire stlt_word_t wr_odd,
    input  wire stlt_size_t wr_size,
    // Read return, held until the next write
    output stlt_word_t      rd_even,
    output stlt_word_t      rd_odd,
    output stlt_size_t      rd_size
);
    timeunit 1ns;
    timeprecision 1ns;

    // One entry is enough to see both halves and the size travel both ways
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_even <= '0;
            rd_odd  <= '0;
            rd_size <= '0;
        end
        else if (wr)
        begin
            rd_even <= wr_even;
            rd_odd  <= wr_odd;
            rd_size <= wr_size;
        end
    end
endmodule : stlt_tlb_model
`default_nettype wire

// ==== tb/sysctl_tlb_timer_regs_tb.sv ====
// Self-checking bench for the TLB staging and timer registers
`include "stlt_defs.svh"
`default_nettype none
module sysctl_tlb_timer_regs_tb
    import stlt_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n, ce, kernel_mode, sysctl_usable_bit, wide_ops, mt_valid, mf_valid;
    logic tlb_write, tlb_write_random, tlb_read, xlat_hit, xlat_entry_ok, xlat_store;
    logic tlb_miss, addr_error, hold_fault, graduate, bus_addr_cycle, int_enable_bit7;
    logic mf_done_q, unusable_exc_q, tlb_wr_q, tlb_wr_shared_q, tlb_inv_load_q;
    logic tlb_inv_store_q, pending_int_bit7_q, timer_irq_q;
    logic [1:0] bus_entry_nc, system_bus_nc_q;
    logic [5:0] tlb_wr_index_q, repl_ptr_q;
    logic [27:0] frame_bit_filter;
    stlt_sel_t mt_sel, mf_sel;
    stlt_word_t mt_wdata, fault_vaddr, mf_rdata_q, tlb_wr_even_q, tlb_wr_odd_q;
    stlt_word_t tlb_rd_even, tlb_rd_odd;
    stlt_size_t tlb_rd_size, tlb_wr_size_q;
    int miscompares = 0;
    int tests_run = 0;

    stlt_regs dut_u (.clk, .rst_n, .ce, .kernel_mode, .sysctl_usable_bit, .wide_ops,
        .mt_valid, .mt_sel, .mt_wdata, .mf_valid, .mf_sel, .mf_rdata_q, .mf_done_q,
        .unusable_exc_q, .tlb_write, .tlb_write_random, .tlb_read, .tlb_rd_even,
        .tlb_rd_odd, .tlb_rd_size, .frame_bit_filter, .tlb_wr_q, .tlb_wr_even_q,
        .tlb_wr_odd_q, .tlb_wr_shared_q, .tlb_wr_size_q, .tlb_wr_index_q, .repl_ptr_q,
        .xlat_hit, .xlat_entry_ok, .xlat_store, .tlb_miss, .addr_error, .hold_fault,
        .fault_vaddr, .tlb_inv_load_q, .tlb_inv_store_q, .graduate, .bus_addr_cycle,
        .bus_entry_nc, .system_bus_nc_q, .int_enable_bit7, .pending_int_bit7_q, .timer_irq_q);

    stlt_tlb_model tlb_u (.clk, .rst_n, .wr(tlb_wr_q), .wr_even(tlb_wr_even_q),
        .wr_odd(tlb_wr_odd_q), .wr_size(tlb_wr_size_q), .rd_even(tlb_rd_even),
        .rd_odd(tlb_rd_odd), .rd_size(tlb_rd_size));

    // Free-running processor clock
    always #4 clk = ~clk;

    task automatic chk(input string n, input stlt_word_t e, input stlt_word_t g);
        tests_run++;
        if (g !== e)
        begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask : chk

    // Move-to: one request cycle, ends just after the taking edge
    task automatic wr(input stlt_sel_t s, input stlt_word_t d);
        @(posedge clk);
        mt_valid <= 1'b1;
        mt_sel   <= s;
        mt_wdata <= d;
        @(posedge clk);
        mt_valid <= 1'b0;
        #1;
    endtask : wr

    // Move-from: answer lands on the edge that takes the request; data is checked one cycle later
    task automatic rd(input stlt_sel_t s, input stlt_word_t e, input string n);
        @(posedge clk);
        mf_valid <= 1'b1;
        mf_sel   <= s;
        @(posedge clk);
        mf_valid <= 1'b0;
        #1;
        chk("done", 64'h1, {63'h0, mf_done_q});
        @(posedge clk);
        #1;
        chk(n, e, mf_rdata_q);
    endtask : rd

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // Generous bound; the sequence needs well under a thousand cycles
    initial
    begin
        #20000;
        miscompares++;
        test_done();
    end

    initial
    begin
        {rst_n, mt_valid, mf_valid, tlb_write, tlb_write_random, tlb_read} = '0;
        {xlat_hit, xlat_entry_ok, xlat_store, tlb_miss, addr_error, hold_fault} = '0;
        {graduate, bus_addr_cycle, int_enable_bit7, sysctl_usable_bit} = '0;
        {ce, kernel_mode, wide_ops} = 3'h7;
        {mt_sel, mf_sel, mt_wdata, fault_vaddr, bus_entry_nc, frame_bit_filter} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("repl_ptr", 64'h3F, {58'h0, repl_ptr_q});
        rd(`STLT_OFF_FIXED, 64'h0, "boundary");
        wr(`STLT_OFF_FIXED, 64'h5);
        chk("repl_ptr", 64'h3F, {58'h0, repl_ptr_q});
        @(posedge clk);
        graduate <= 1'b1;
        @(posedge clk);
        graduate <= 1'b0;
        #1;
        chk("repl_ptr", 64'h3E, {58'h0, repl_ptr_q});
        @(posedge clk);
        kernel_mode <= 1'b0;
        wr(`STLT_OFF_FIXED, 64'h9);
        chk("unusable", 64'h1, {63'h0, unusable_exc_q});
        kernel_mode <= 1'b1;
        rd(`STLT_OFF_FIXED, 64'h5, "boundary");
        rd(5'h07, 64'h0, "unmapped");
        $display("test pointer done");
        wr(`STLT_OFF_EVEN, 64'hFFFF_FFFF_FFFF_FFFF);
        rd(`STLT_OFF_EVEN, 64'hC000_0003_FFFF_FFFF, "even");
        wr(`STLT_OFF_ODD, 64'h1);
        wr(`STLT_OFF_SIZE, 64'h6000);
        @(posedge clk);
        tlb_write        <= 1'b1;
        tlb_write_random <= 1'b1;
        frame_bit_filter <= 28'h000_0001;
        @(posedge clk);
        {tlb_write, tlb_write_random} <= 2'h0;
        #1;
        chk("wr_even", 64'hC000_0003_FFFF_FFBF, tlb_wr_even_q);
        chk("index", 64'h3E, {58'h0, tlb_wr_index_q});
        chk("size", 64'h3, {52'h0, tlb_wr_size_q});
        chk("shared", 64'h1, {63'h0, tlb_wr_shared_q});
        wr(`STLT_OFF_EVEN, 64'h0);
        @(posedge clk);
        tlb_read <= 1'b1;
        @(posedge clk);
        tlb_read <= 1'b0;
        rd(`STLT_OFF_EVEN, 64'hC000_0003_FFFF_FFBF, "even");
        wide_ops <= 1'b0;
        wr(`STLT_OFF_ODD, 64'h8000_0000);
        wide_ops <= 1'b1;
        rd(`STLT_OFF_ODD, 64'h0000_0003_8000_0000, "odd");
        $display("test descriptor done");
        wr(`STLT_OFF_MISS, 64'hFFFF_FFFF_FF80_0000);
        @(posedge clk);
        tlb_miss    <= 1'b1;
        fault_vaddr <= 64'hABCD_E000;
        xlat_hit    <= 1'b1;
        xlat_store  <= 1'b1;
        bus_addr_cycle <= 1'b1;
        bus_entry_nc   <= 2'h2;
        @(posedge clk);
        {tlb_miss, xlat_hit, xlat_store, bus_addr_cycle} <= '0;
        #1;
        chk("inv_store", 64'h1, {63'h0, tlb_inv_store_q});
        chk("inv_load", 64'h0, {63'h0, tlb_inv_load_q});
        chk("bus_nc", 64'h2, {62'h0, system_bus_nc_q});
        rd(`STLT_OFF_MISS, 64'hFFFF_FFFF_FFD5_E6F0, "miss_ptr");
        @(posedge clk);
        {addr_error, hold_fault} <= 2'h3;
        fault_vaddr <= 64'h1234;
        @(posedge clk);
        {addr_error, hold_fault} <= 2'h0;
        rd(`STLT_OFF_FAULT, 64'hABCD_E000, "fault");
        $display("test fault done");
        wr(`STLT_OFF_TICK, 64'hFFFF_FFFE);
        wr(`STLT_OFF_MATCH, 64'h0);
        int_enable_bit7 <= 1'b1;
        // Flag from the reset-time match must drain first
        repeat (2) @(posedge clk);
        #1;
        for (int i = 0; i < 20 && pending_int_bit7_q !== 1'b1; i++)
            @(posedge clk);
        repeat (2) @(posedge clk);
        #1;
        chk("pending", 64'h1, {63'h0, pending_int_bit7_q});
        chk("irq", 64'h1, {63'h0, timer_irq_q});
        wr(`STLT_OFF_MATCH, 64'h1000);
        repeat (3) @(posedge clk);
        #1;
        chk("pending", 64'h0, {63'h0, pending_int_bit7_q});
        rd(`STLT_OFF_MATCH, 64'h1000, "match");
        $display("test timer done");
        test_done();
    end
endmodule : sysctl_tlb_timer_regs_tb
`default_nettype wire
